// ===== src/event_trigger_pkg.sv
package event_trigger_pkg;

   // Register byte offsets on the bus.
   localparam logic [11:0] OFS_SELECT = 12'h000;
   localparam logic [11:0] OFS_PRESCALE = 12'h004;
   localparam logic [11:0] OFS_STATUS = 12'h008;
   localparam logic [11:0] OFS_MASK = 12'h00c;
   localparam int ADDR_BITS = 12;

   localparam logic [15:0] SELECT_RESET = 16'h0000;
   localparam logic [15:0] PRESCALE_RESET = 16'h0000;
   localparam logic [2:0] STATUS_RESET = 3'h0;
   localparam logic [2:0] MASK_RESET = 3'h0;

   // Channel order everywhere: conversion start A, conversion start B, interrupt.
   localparam int NUM_CHAN = 3;
   localparam int CH_CONV_A = 0;
   localparam int CH_CONV_B = 1;
   localparam int CH_IRQ = 2;

   // Field positions, indexed by channel.
   localparam int SEL_LSB [NUM_CHAN] = '{8, 12, 0};
   localparam int EN_BIT [NUM_CHAN] = '{11, 15, 3};
   localparam int PRD_LSB [NUM_CHAN] = '{8, 12, 0};
   localparam int CNT_LSB [NUM_CHAN] = '{10, 14, 2};
   localparam logic [15:0] PRESCALE_WR_MASK = 16'h3303;

   // Shared event source codes.
   localparam logic [2:0] EV_NONE_0 = 3'h0;
   localparam logic [2:0] EV_ZERO = 3'h1;
   localparam logic [2:0] EV_PERIOD = 3'h2;
   localparam logic [2:0] EV_NONE_3 = 3'h3;
   localparam logic [2:0] EV_COMPARE_VALUE_FIRST_UP = 3'h4;
   localparam logic [2:0] EV_COMPARE_VALUE_FIRST_DOWN = 3'h5;
   localparam logic [2:0] EV_COMPARE_VALUE_SECOND_UP = 3'h6;
   localparam logic [2:0] EV_COMPARE_VALUE_SECOND_DOWN = 3'h7;

   localparam logic [1:0] CNT_MAX = 2'h3;
   localparam logic [1:0] PRD_OFF = 2'h0;

   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic [1:0] HRESP_OKAY = 2'h0;

   // Time-base view from the sibling counter and compare logic.
   typedef struct packed {
      logic [15:0] count;
      logic [15:0] period;
      logic [15:0] cmp_a;
      logic [15:0] cmp_b;
      logic count_up;
   } time_base_t;

   // Pulses leaving the block, one cycle each.
   typedef struct packed {
      logic conv_a_start_pulse;
      logic conv_b_start_pulse;
      logic module_irq;
   } trigger_out_t;

endpackage

// ===== src/pwm_event_trigger_select.sv
// Design decisions made here: the AHB-Lite slave port and the register offsets.
`timescale 1ns/1ps

module pwm_event_trigger_select (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic [1:0] hresp,
   output logic [31:0] hrdata,
   input wire event_trigger_pkg::time_base_t time_base,
   output event_trigger_pkg::trigger_out_t trig,
   output logic irq
);

   logic [15:0] event_select_register;
   logic [15:0] prd_field;
   logic [1:0] cnt [event_trigger_pkg::NUM_CHAN];
   logic [2:0] pulse;
   logic [2:0] status;
   logic [2:0] mask;
   logic [7:0] ev_now;
   logic [7:0] ev_prev;
   logic [7:0] ev_edge;
   logic [15:0] prescale_view;
   logic wr_pend;
   logic rd_pend;
   logic rd_wait;
   logic [11:0] dp_addr;
   logic addr_take;

   // Event match for one source code; reserved codes never match.
   function automatic logic code_hit(input logic [2:0] code,
                                     input event_trigger_pkg::time_base_t tb);
      logic hit;
      hit = 1'b0;
      unique case (code)
         event_trigger_pkg::EV_ZERO: hit = (tb.count == 16'h0000);
         event_trigger_pkg::EV_PERIOD: hit = (tb.count == tb.period);
         event_trigger_pkg::EV_COMPARE_VALUE_FIRST_UP: hit = (tb.count == tb.cmp_a) && tb.count_up;
         event_trigger_pkg::EV_COMPARE_VALUE_FIRST_DOWN: hit = (tb.count == tb.cmp_a) && !tb.count_up;
         event_trigger_pkg::EV_COMPARE_VALUE_SECOND_UP: hit = (tb.count == tb.cmp_b) && tb.count_up;
         event_trigger_pkg::EV_COMPARE_VALUE_SECOND_DOWN: hit = (tb.count == tb.cmp_b) && !tb.count_up;
         event_trigger_pkg::EV_NONE_0, event_trigger_pkg::EV_NONE_3: hit = 1'b0;
      endcase
      return hit;
   endfunction

   // A counter may rest on a value for several clocks; only the first clock of a
   // match counts as an event so that a stalled time base does not flood the output.
   always_comb begin
      for (int c = 0; c < 8; c++) begin
         ev_now[c] = code_hit(3'(c), time_base);
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ev_prev <= 8'h00;
      end else begin
         ev_prev <= ev_now;
      end
   end

   assign ev_edge = ev_now & ~ev_prev;

   // Per-channel event counting and pulse generation.
   genvar ch;
   generate
      for (ch = 0; ch < event_trigger_pkg::NUM_CHAN; ch++) begin : g_chan
         logic [2:0] src;
         logic en;
         logic [1:0] prd;
         logic hit;
         logic [1:0] next_cnt;
         logic fire;

         assign src = event_select_register[event_trigger_pkg::SEL_LSB[ch] +: 3];
         assign en = event_select_register[event_trigger_pkg::EN_BIT[ch]];
         assign prd = prd_field[event_trigger_pkg::PRD_LSB[ch] +: 2];
         assign hit = ev_edge[src];
         assign next_cnt = (cnt[ch] == event_trigger_pkg::CNT_MAX) ? cnt[ch] :
                           cnt[ch] + 2'h1;
         // Gate by enable and period reach.
         assign fire = hit && en && (prd != event_trigger_pkg::PRD_OFF) && (next_cnt >= prd);

         // Same counter behaviour on every channel.
         always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
               cnt[ch] <= 2'h0;
            end else if (prd == event_trigger_pkg::PRD_OFF) begin
               cnt[ch] <= 2'h0;
            end else if (fire) begin
               cnt[ch] <= 2'h0;
            end else if (hit) begin
               cnt[ch] <= next_cnt;
            end
         end

         // Pulse is independent of the sticky status bit.
         always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
               pulse[ch] <= 1'b0;
            end else begin
               pulse[ch] <= fire;
            end
         end
      end
   endgenerate

   assign trig.conv_a_start_pulse = pulse[event_trigger_pkg::CH_CONV_A];
   assign trig.conv_b_start_pulse = pulse[event_trigger_pkg::CH_CONV_B];
   assign trig.module_irq = pulse[event_trigger_pkg::CH_IRQ];

   // AHB-Lite address phase capture.
   assign addr_take = hsel && hready && (htrans == event_trigger_pkg::HTRANS_NONSEQ);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend <= 1'b0;
         rd_pend <= 1'b0;
         dp_addr <= 12'h000;
      end else if (hreadyout) begin
         wr_pend <= addr_take && hwrite;
         rd_pend <= addr_take && !hwrite;
         if (addr_take) begin
            dp_addr <= haddr[event_trigger_pkg::ADDR_BITS-1:0];
         end
      end
   end

   // Reads take one wait state so that hrdata comes from a flop and still sees
   // a write that completed in the cycle just before.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rd_wait <= 1'b0;
      end else begin
         rd_wait <= rd_pend && !rd_wait;
      end
   end

   assign hreadyout = !(rd_pend && !rd_wait);
   assign hresp = event_trigger_pkg::HRESP_OKAY;

   always_comb begin
      prescale_view = prd_field;
      for (int c = 0; c < event_trigger_pkg::NUM_CHAN; c++) begin
         prescale_view[event_trigger_pkg::CNT_LSB[c] +: 2] = cnt[c];
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h00000000;
      end else if (rd_pend && !rd_wait) begin
         unique case (dp_addr)
            event_trigger_pkg::OFS_SELECT: hrdata <= {16'h0000, event_select_register};
            event_trigger_pkg::OFS_PRESCALE: hrdata <= {16'h0000, prescale_view};
            event_trigger_pkg::OFS_STATUS: hrdata <= {29'h00000000, status};
            event_trigger_pkg::OFS_MASK: hrdata <= {29'h00000000, mask};
            default: hrdata <= 32'h00000000;
         endcase
      end
   end

   // Select register clears on reset; bits 7-4 stay zero.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         event_select_register <= event_trigger_pkg::SELECT_RESET;
      end else if (wr_pend && dp_addr == event_trigger_pkg::OFS_SELECT) begin
         event_select_register <= hwdata[15:0] & 16'hff0f;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         prd_field <= event_trigger_pkg::PRESCALE_RESET;
      end else if (wr_pend && dp_addr == event_trigger_pkg::OFS_PRESCALE) begin
         prd_field <= hwdata[15:0] & event_trigger_pkg::PRESCALE_WR_MASK;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         mask <= event_trigger_pkg::MASK_RESET;
      end else if (wr_pend && dp_addr == event_trigger_pkg::OFS_MASK) begin
         mask <= hwdata[2:0];
      end
   end

   // Sticky status, write one to clear; a new pulse in the clearing cycle wins.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         status <= event_trigger_pkg::STATUS_RESET;
      end else if (wr_pend && dp_addr == event_trigger_pkg::OFS_STATUS) begin
         status <= (status & ~hwdata[2:0]) | pulse;
      end else begin
         status <= status | pulse;
      end
   end

   assign irq = |(status & mask);

   // Checks.

   property p_conv_b_gated;
      @(posedge hclk) disable iff (!hresetn)
      trig.conv_b_start_pulse |-> $past(event_select_register[15]);
   endproperty
   a_conv_b_gated: assert property (p_conv_b_gated)
      else $error("conversion B pulse without its enable");

   property p_conv_a_gated;
      @(posedge hclk) disable iff (!hresetn)
      trig.conv_a_start_pulse |-> $past(event_select_register[11]);
   endproperty
   a_conv_a_gated: assert property (p_conv_a_gated)
      else $error("conversion A pulse without its enable");

   property p_irq_gated;
      @(posedge hclk) disable iff (!hresetn)
      trig.module_irq |-> $past(event_select_register[3]);
   endproperty
   a_irq_gated: assert property (p_irq_gated)
      else $error("module interrupt without its enable");

   property p_zero_first;
      @(posedge hclk) disable iff (!hresetn)
      (event_select_register[10:8] == 3'h1 && event_select_register[11] &&
       prd_field[9:8] == 2'h1 && time_base.count == 16'h0000 && !ev_prev[1])
      |=> trig.conv_a_start_pulse;
   endproperty
   a_zero_first: assert property (p_zero_first)
      else $error("zero event missed on conversion A");

   property p_compare_value_second_down;
      @(posedge hclk) disable iff (!hresetn)
      ev_edge[7] |-> (time_base.count == time_base.cmp_b) && !time_base.count_up;
   endproperty
   a_compare_value_second_down: assert property (p_compare_value_second_down)
      else $error("compare B down event without its cause");

   property p_reserved_quiet;
      @(posedge hclk) disable iff (!hresetn)
      !ev_edge[0] && !ev_edge[3];
   endproperty
   a_reserved_quiet: assert property (p_reserved_quiet)
      else $error("reserved code produced an event");

   property p_clear_on_pulse;
      @(posedge hclk) disable iff (!hresetn)
      trig.conv_b_start_pulse |-> cnt[event_trigger_pkg::CH_CONV_B] == 2'h0;
   endproperty
   a_clear_on_pulse: assert property (p_clear_on_pulse)
      else $error("event count not cleared after pulse");

   property p_third_event;
      @(posedge hclk) disable iff (!hresetn)
      (trig.conv_b_start_pulse && $past(prd_field[13:12]) == 2'h3) |->
      $past(cnt[event_trigger_pkg::CH_CONV_B]) == 2'h2;
   endproperty
   a_third_event: assert property (p_third_event)
      else $error("period three pulse on wrong event");

   property p_pulse_sets_flag;
      @(posedge hclk) disable iff (!hresetn)
      trig.conv_a_start_pulse |=> status[event_trigger_pkg::CH_CONV_A] ##1 1'b1;
   endproperty
   a_pulse_sets_flag: assert property (p_pulse_sets_flag)
      else $error("status flag not set by pulse");

   property p_conv_b_source;
      @(posedge hclk) disable iff (!hresetn)
      trig.conv_b_start_pulse |-> $past(ev_now[event_select_register[14:12]]);
   endproperty
   a_conv_b_source: assert property (p_conv_b_source)
      else $error("conversion B pulse from an unselected source");

   property p_conv_a_source;
      @(posedge hclk) disable iff (!hresetn)
      trig.conv_a_start_pulse |-> $past(ev_now[event_select_register[10:8]]);
   endproperty
   a_conv_a_source: assert property (p_conv_a_source)
      else $error("conversion A pulse from an unselected source");

   property p_irq_source;
      @(posedge hclk) disable iff (!hresetn)
      trig.module_irq |-> $past(ev_now[event_select_register[2:0]]);
   endproperty
   a_irq_source: assert property (p_irq_source)
      else $error("module interrupt from an unselected source");

   property p_period_event;
      @(posedge hclk) disable iff (!hresetn)
      ev_edge[2] |-> time_base.count == time_base.period;
   endproperty
   a_period_event: assert property (p_period_event)
      else $error("period event without its cause");

   property p_compare_value_first_up;
      @(posedge hclk) disable iff (!hresetn)
      ev_edge[4] |-> (time_base.count == time_base.cmp_a) && time_base.count_up;
   endproperty
   a_compare_value_first_up: assert property (p_compare_value_first_up)
      else $error("compare A up event without its cause");

   property p_compare_value_first_down;
      @(posedge hclk) disable iff (!hresetn)
      ev_edge[5] |-> (time_base.count == time_base.cmp_a) && !time_base.count_up;
   endproperty
   a_compare_value_first_down: assert property (p_compare_value_first_down)
      else $error("compare A down event without its cause");

   property p_compare_value_second_up;
      @(posedge hclk) disable iff (!hresetn)
      ev_edge[6] |-> (time_base.count == time_base.cmp_b) && time_base.count_up;
   endproperty
   a_compare_value_second_up: assert property (p_compare_value_second_up)
      else $error("compare B up event without its cause");

   property p_period_off_b;
      @(posedge hclk) disable iff (!hresetn)
      prd_field[13:12] == 2'h0 |=> !trig.conv_b_start_pulse;
   endproperty
   a_period_off_b: assert property (p_period_off_b)
      else $error("conversion B pulse with its counter disabled");

   property p_period_off_irq;
      @(posedge hclk) disable iff (!hresetn)
      prd_field[1:0] == 2'h0 |=> !trig.module_irq;
   endproperty
   a_period_off_irq: assert property (p_period_off_irq)
      else $error("module interrupt with its counter disabled");

   property p_select_reset;
      @(posedge hclk)
      $rose(hresetn) |-> event_select_register == event_trigger_pkg::SELECT_RESET &&
      prd_field == event_trigger_pkg::PRESCALE_RESET;
   endproperty
   a_select_reset: assert property (p_select_reset)
      else $error("configuration not cleared by reset");

   property p_count_not_written;
      @(posedge hclk) disable iff (!hresetn)
      (wr_pend && dp_addr == event_trigger_pkg::OFS_PRESCALE) |=>
      (prd_field & ~event_trigger_pkg::PRESCALE_WR_MASK) == 16'h0000;
   endproperty
   a_count_not_written: assert property (p_count_not_written)
      else $error("event count bits taken from write data");

   property p_clear_on_irq;
      @(posedge hclk) disable iff (!hresetn)
      trig.module_irq |-> cnt[event_trigger_pkg::CH_IRQ] == 2'h0;
   endproperty
   a_clear_on_irq: assert property (p_clear_on_irq)
      else $error("interrupt event count not cleared after pulse");

endmodule

// ===== tb/time_base_model.sv
`timescale 1ns/1ps

module time_base_model #(
   parameter int PERIOD = 10,
   parameter int CMP_A = 3,
   parameter int CMP_B = 7
) (
   input wire logic hclk,
   input wire logic hresetn,
   output event_trigger_pkg::time_base_t time_base
);
   logic [15:0] count;
   logic count_up;

   // An up-down sweep makes every event source occur exactly once per sweep.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         count <= 16'h0000;
         count_up <= 1'b1;
      end else if (count_up) begin
         count <= count + 16'h0001;
         count_up <= (count != 16'(PERIOD - 1));
      end else begin
         count <= count - 16'h0001;
         count_up <= (count == 16'h0001);
      end
   end

   assign time_base = '{count: count, period: 16'(PERIOD), cmp_a: 16'(CMP_A),
                        cmp_b: 16'(CMP_B), count_up: count_up};
endmodule

// ===== tb/pwm_event_trigger_select_bench.sv
`timescale 1ns/1ps

module pwm_event_trigger_select_bench;
   localparam int SWEEP = 20;
   logic hclk, hresetn, hsel, hwrite, hready, hreadyout, irq;
   logic [1:0] htrans, hresp;
   logic [2:0] hsize, pulses;
   logic [31:0] haddr, hwdata, hrdata;
   event_trigger_pkg::time_base_t time_base;
   event_trigger_pkg::trigger_out_t trig;
   int errors = 0;
   int n_tests = 0;
   int cycles = 0;
   int pc [3] = '{0, 0, 0};

   assign hready = hreadyout;
   assign pulses = {trig.module_irq, trig.conv_b_start_pulse, trig.conv_a_start_pulse};

   time_base_model #(.PERIOD(SWEEP / 2)) time_base_model_inst (
      .hclk(hclk), .hresetn(hresetn), .time_base(time_base));

   pwm_event_trigger_select pwm_event_trigger_select_inst (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .time_base(time_base),
      .trig(trig), .irq(irq));

   initial begin
      hclk = 1'b0;
      forever #10 hclk = ~hclk;
   end

   // Pulses are tallied on the falling edge, so a window opened and closed on rising
   // edges never races the tally and sees exactly its own cycles.
   always @(negedge hclk) begin
      for (int i = 0; i < 3; i++) begin
         pc[i] += int'(pulses[i]);
      end
   end

   always @(posedge hclk) begin
      cycles++;
      if (cycles == 20000) begin
         errors++;
         tally_and_finish();
      end
   end

   task automatic tally_and_finish();
      $display("errors %0d of %0d checks", errors, n_tests);
      if (errors == 0 && n_tests > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      n_tests++;
      if (got !== exp) begin
         errors++;
         $display("wrong value %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                       output logic [31:0] rd);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= {20'h00000, a};
      htrans <= event_trigger_pkg::HTRANS_NONSEQ;
      hwrite <= wr;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] x;
      xfer(1'b1, a, d, x);
   endtask

   task automatic rd_chk(input string name, input logic [11:0] a, input logic [31:0] exp);
      logic [31:0] x;
      xfer(1'b0, a, 32'h0, x);
      chk(name, exp, x);
      chk("hresp", {30'h0, event_trigger_pkg::HRESP_OKAY}, {30'h0, hresp});
   endtask

   task automatic setup(input int ch, input int code, input int en, input int prd);
      wr(event_trigger_pkg::OFS_PRESCALE, 32'(prd) << event_trigger_pkg::PRD_LSB[ch]);
      wr(event_trigger_pkg::OFS_SELECT, (32'(en) << event_trigger_pkg::EN_BIT[ch]) |
         (32'(code) << event_trigger_pkg::SEL_LSB[ch]));
   endtask

   task automatic pulses_in(input int ch, input int n, input int exp, input string name);
      int s;
      s = pc[ch];
      repeat (n) @(posedge hclk);
      chk(name, 32'(exp), 32'(pc[ch] - s));
   endtask

   task automatic irq_chk(input logic e);
      @(posedge hclk);
      #1;
      chk("irq", {31'h0, e}, {31'h0, irq});
   endtask

   task automatic test_regs();
      rd_chk("select", event_trigger_pkg::OFS_SELECT, 32'h0);
      rd_chk("prescale", event_trigger_pkg::OFS_PRESCALE, 32'h0);
      rd_chk("status", event_trigger_pkg::OFS_STATUS, 32'h0);
      rd_chk("mask", event_trigger_pkg::OFS_MASK, 32'h0);
      wr(event_trigger_pkg::OFS_PRESCALE, 32'hffffffff);
      rd_chk("prescale", event_trigger_pkg::OFS_PRESCALE, 32'h3303);
      wr(event_trigger_pkg::OFS_SELECT, 32'hffffffff);
      rd_chk("select", event_trigger_pkg::OFS_SELECT, 32'hff0f);
      wr(event_trigger_pkg::OFS_SELECT, 32'h0);
      wr(12'h010, 32'hffffffff);
      rd_chk("unmapped", 12'h010, 32'h0);
   endtask

   // Every code is tried on every channel; each real event occurs once per sweep.
   task automatic test_codes();
      for (int ch = 0; ch < 3; ch++) begin
         for (int code = 0; code < 8; code++) begin
            setup(ch, code, 1, 1);
            repeat (SWEEP) @(posedge hclk);
            case (code)
               0, 3: pulses_in(ch, SWEEP, 0, "reserved code pulses");
               1: pulses_in(ch, SWEEP, 1, "zero code pulses");
               2: pulses_in(ch, SWEEP, 1, "period code pulses");
               4: pulses_in(ch, SWEEP, 1, "compare A up pulses");
               5: pulses_in(ch, SWEEP, 1, "compare A down pulses");
               6: pulses_in(ch, SWEEP, 1, "compare B up pulses");
               default: pulses_in(ch, SWEEP, 1, "compare B down pulses");
            endcase
         end
      end
   endtask

   // Three sweeps hold three zero events, so a disabled channel's count rests at three.
   task automatic test_enable();
      logic [31:0] e;
      for (int ch = 0; ch < 3; ch++) begin
         setup(ch, 1, 0, 1);
         pulses_in(ch, 2 * SWEEP, 0, "disabled pulses");
         repeat (SWEEP) @(posedge hclk);
         e = 32'h1 << event_trigger_pkg::PRD_LSB[ch];
         e |= 32'h3 << event_trigger_pkg::CNT_LSB[ch];
         rd_chk("saturated count", event_trigger_pkg::OFS_PRESCALE, e);
      end
   endtask

   // Status stays set across the window, so later pulses prove it does not block them.
   task automatic test_period();
      logic [31:0] x;
      for (int ch = 0; ch < 3; ch++) begin
         for (int p = 0; p < 4; p++) begin
            setup(ch, 0, 0, 0);
            setup(ch, 1, 1, p);
            // One edge more than six sweeps: the write edge itself can never fire.
            pulses_in(ch, 6 * SWEEP + 1, (p == 0) ? 0 : 6 / p, "period");
         end
         xfer(1'b0, event_trigger_pkg::OFS_STATUS, 32'h0, x);
         chk("status bit", 32'h1, {31'h0, x[ch]});
      end
   endtask

   task automatic test_irq();
      wr(event_trigger_pkg::OFS_SELECT, 32'h0);
      wr(event_trigger_pkg::OFS_STATUS, 32'h7);
      rd_chk("status", event_trigger_pkg::OFS_STATUS, 32'h0);
      setup(event_trigger_pkg::CH_IRQ, 2, 1, 1);
      repeat (SWEEP) @(posedge hclk);
      wr(event_trigger_pkg::OFS_SELECT, 32'h0);
      rd_chk("status", event_trigger_pkg::OFS_STATUS, 32'h4);
      irq_chk(1'b0);
      wr(event_trigger_pkg::OFS_MASK, 32'h1);
      irq_chk(1'b0);
      wr(event_trigger_pkg::OFS_MASK, 32'h4);
      irq_chk(1'b1);
      rd_chk("mask", event_trigger_pkg::OFS_MASK, 32'h4);
      wr(event_trigger_pkg::OFS_STATUS, 32'h4);
      irq_chk(1'b0);
      rd_chk("status", event_trigger_pkg::OFS_STATUS, 32'h0);
   endtask

   initial begin
      hresetn = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
      repeat (4) @(posedge hclk);
      hresetn <= 1'b1;
      test_regs();
      test_codes();
      test_enable();
      test_period();
      test_irq();
      tally_and_finish();
   end
endmodule
